// ===== rtl/deep_sleep_peripheral_clock_gate.sv
`timescale 1ns/1ns
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module deep_sleep_peripheral_clock_gate
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire clk_gate_pkg::reg_req_t req,
   output clk_gate_pkg::reg_rsp_t rsp,
   input wire logic sleep_req,
   input wire logic deep_req,
   input wire clk_gate_pkg::periph_req_t periph,
   output logic bus_fault,
   output logic [clk_gate_pkg::NUM_UNITS-1:0] unit_clk,
   output logic [clk_gate_pkg::NUM_UNITS-1:0] unit_enable
);
   import clk_gate_pkg::*;

   logic [31:0] run_gate_q, run_gate_d;
   logic [31:0] sleep_gate_q, sleep_gate_d;
   logic [31:0] deep_gate_q, deep_gate_d;
   logic [31:0] run_cfg_q, run_cfg_d;
   reg_rsp_t rsp_q, rsp_d;
   power_mode_t mode_q, mode_d;
   logic sleep_s1_q, sleep_s2_q, deep_s1_q, deep_s2_q;
   logic fault_q, fault_d;
   logic [31:0] active_gate;
   logic [NUM_UNITS-1:0] unit_sel_en;
   logic [NUM_UNITS-1:0] gate_en_q;

   //////////////////////////////////////////////////////////////////////////
   // Register writes and reads
   always_comb begin
      run_gate_d = run_gate_q;
      sleep_gate_d = sleep_gate_q;
      deep_gate_d = deep_gate_q;
      run_cfg_d = run_cfg_q;
      rsp_d = '{rdata: READ_IDLE, unmapped: 1'b0};
      // A write and a read in one cycle count as a write; the read is lost
      if (req.wr) begin
         case (req.addr)
            OFS_RUN_GATE: run_gate_d = req.wdata & GATE_MASK;
            OFS_SLEEP_GATE: sleep_gate_d = req.wdata & GATE_MASK;
            OFS_DEEP_GATE: deep_gate_d = req.wdata & GATE_MASK;
            OFS_RUN_CFG: run_cfg_d = req.wdata & RUN_CFG_MASK;
            default: rsp_d.unmapped = 1'b1;
         endcase
      end else if (req.rd) begin
         // Masked storage keeps reserved bits at zero on read
         case (req.addr)
            OFS_RUN_GATE: rsp_d.rdata = run_gate_q;
            OFS_SLEEP_GATE: rsp_d.rdata = sleep_gate_q;
            OFS_DEEP_GATE: rsp_d.rdata = deep_gate_q;
            OFS_RUN_CFG: rsp_d.rdata = run_cfg_q;
            OFS_POWER_MODE: rsp_d.rdata = {30'h0000_0000, mode_q};
            default: rsp_d.unmapped = 1'b1;
         endcase
      end
   end

   // Reset leaves every unit unclocked
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         run_gate_q <= GATE_RESET;
         sleep_gate_q <= GATE_RESET;
         deep_gate_q <= GATE_RESET;
         run_cfg_q <= RUN_CFG_RESET;
         rsp_q <= '{rdata: READ_IDLE, unmapped: 1'b0};
      end else begin
         run_gate_q <= run_gate_d;
         sleep_gate_q <= sleep_gate_d;
         deep_gate_q <= deep_gate_d;
         run_cfg_q <= run_cfg_d;
         rsp_q <= rsp_d;
      end
   end

   assign rsp = rsp_q;

   //////////////////////////////////////////////////////////////////////////
   // Power mode from synchronised request pins
   // The first flop may go metastable, so only the second one is read
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sleep_s1_q <= 1'b0;
         sleep_s2_q <= 1'b0;
         deep_s1_q <= 1'b0;
         deep_s2_q <= 1'b0;
      end else begin
         sleep_s1_q <= sleep_req;
         sleep_s2_q <= sleep_s1_q;
         deep_s1_q <= deep_req;
         deep_s2_q <= deep_s1_q;
      end
   end

   // Steps one Gray code at a time so only one mode bit ever flips
   // Deep-sleep wins over sleep; leaving deep-sleep passes through sleep
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         MODE_RUN: begin
            if (sleep_s2_q || deep_s2_q) begin
               mode_d = MODE_SLEEP;
            end
         end
         MODE_SLEEP: begin
            if (deep_s2_q) begin
               mode_d = MODE_DEEP;
            end else if (!sleep_s2_q) begin
               mode_d = MODE_RUN;
            end
         end
         MODE_DEEP: begin
            if (!deep_s2_q) begin
               mode_d = MODE_SLEEP;
            end
         end
         default: mode_d = MODE_RUN;
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_q <= MODE_RUN;
      end else begin
         mode_q <= mode_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Gate source selection; without auto-gating the run set always applies
   always_comb begin
      active_gate = run_gate_q;
      if (run_cfg_q[BIT_AUTO_GATING]) begin
         case (mode_q)
            MODE_SLEEP: active_gate = sleep_gate_q;
            MODE_DEEP: active_gate = deep_gate_q;
            default: active_gate = run_gate_q;
         endcase
      end
   end

   // Gate bits mapped to unit order, comparator as unit 7
   // A change of NUM_UNITS means extending this list by hand
   assign unit_sel_en = {
      active_gate[BIT_COMPARATOR_ZERO],
      active_gate[BIT_GP_TIMER_TWO],
      active_gate[BIT_GP_TIMER_ONE],
      active_gate[BIT_GP_TIMER_ZERO],
      active_gate[BIT_TWO_WIRE_ZERO],
      active_gate[BIT_SYNC_SERIAL_ZERO],
      active_gate[BIT_ASYNC_SERIAL_ONE],
      active_gate[BIT_ASYNC_SERIAL_ZERO]
   };

   //////////////////////////////////////////////////////////////////////////
   // One glitch-free gate per unit
   for (genvar i = 0; i < NUM_UNITS; i++) begin : g_gate
      unit_clock_gate u_gate (
         .mclk(mclk),
         .sys_rst(sys_rst),
         .enable(unit_sel_en[i]),
         .gated_clk(unit_clk[i]),
         .enable_q(gate_en_q[i])
      );
   end

   assign unit_enable = gate_en_q;

   //////////////////////////////////////////////////////////////////////////
   // Access to a gated unit answers with a fault the next cycle
   // Judged on the applied enable, not the register, so an access in the
   // cycle a gate is being opened still faults
   always_comb begin
      fault_d = periph.access && ((periph.sel & ~gate_en_q) != '0);
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= fault_d;
      end
   end

   assign bus_fault = fault_q;

   //////////////////////////////////////////////////////////////////////////
   // Checks; the enable flops lag the selected register by one cycle,
   // so gate checks compare with the register value one cycle back
   a_deep_reset_zero: assert property (
      @(posedge mclk) $fell(sys_rst) |-> deep_gate_q == GATE_RESET)
      else $error("deep gate not cleared by reset");

   a_units_reset_off: assert property (
      @(posedge mclk) $fell(sys_rst) |-> unit_enable == '0)
      else $error("unit enabled after reset");

   a_reserved_zero: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (deep_gate_q & ~GATE_MASK) == 32'h0000_0000)
      else $error("reserved deep gate bit set");

   a_other_reserved: assert property (
      @(posedge mclk) disable iff (sys_rst)
      ((run_gate_q | sleep_gate_q) & ~GATE_MASK) == 32'h0000_0000)
      else $error("reserved gate bit set");

   a_deep_write_lands: assert property (
      @(posedge mclk) disable iff (sys_rst)
      req.wr && req.addr == OFS_DEEP_GATE
      |=> deep_gate_q == ($past(req.wdata) & GATE_MASK))
      else $error("deep gate write lost");

   a_deep_read_back: assert property (
      @(posedge mclk) disable iff (sys_rst)
      req.rd && !req.wr && req.addr == OFS_DEEP_GATE
      |=> rsp.rdata == $past(deep_gate_q))
      else $error("deep gate read wrong");

   a_deep_is_mapped: assert property (
      @(posedge mclk) disable iff (sys_rst)
      (req.wr || req.rd) && req.addr == OFS_DEEP_GATE |=> !rsp.unmapped)
      else $error("deep gate offset flagged unmapped");

   a_fault_on_gated: assert property (
      @(posedge mclk) disable iff (sys_rst)
      periph.access && (periph.sel & ~gate_en_q) != '0 |=> bus_fault)
      else $error("missing bus fault");

   a_no_fault_open: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !periph.access |=> !bus_fault)
      else $error("spurious bus fault");

   a_no_fault_enabled: assert property (
      @(posedge mclk) disable iff (sys_rst)
      periph.access && (periph.sel & ~gate_en_q) == '0 |=> !bus_fault)
      else $error("bus fault on clocked unit");

   a_deep_applies: assert property (
      @(posedge mclk) disable iff (sys_rst)
      mode_q == MODE_DEEP && run_cfg_q[BIT_AUTO_GATING]
      |=> unit_enable[7] == $past(deep_gate_q[BIT_COMPARATOR_ZERO]))
      else $error("deep gate not applied");

   a_sleep_applies: assert property (
      @(posedge mclk) disable iff (sys_rst)
      mode_q == MODE_SLEEP && run_cfg_q[BIT_AUTO_GATING]
      |=> unit_enable[7] == $past(sleep_gate_q[BIT_COMPARATOR_ZERO]))
      else $error("sleep gate not applied");

   a_run_without_auto: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !run_cfg_q[BIT_AUTO_GATING]
      |=> unit_enable[0] == $past(run_gate_q[BIT_ASYNC_SERIAL_ZERO]))
      else $error("run gate not used");

   a_mode_gray_step: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !(mode_q == MODE_RUN && $past(mode_q) == MODE_DEEP))
      else $error("mode skipped a step");

   a_mode_gray_rise: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !(mode_q == MODE_DEEP && $past(mode_q) == MODE_RUN))
      else $error("mode jumped to deep-sleep");

   a_timer_map: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !run_cfg_q[BIT_AUTO_GATING]
      |=> unit_enable[6:4]
         == $past(run_gate_q[BIT_GP_TIMER_TWO:BIT_GP_TIMER_ZERO]))
      else $error("timer gate map wrong");

   a_serial_map: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !run_cfg_q[BIT_AUTO_GATING]
      |=> unit_enable[3:0] == $past({run_gate_q[BIT_TWO_WIRE_ZERO],
         run_gate_q[BIT_SYNC_SERIAL_ZERO], run_gate_q[BIT_ASYNC_SERIAL_ONE],
         run_gate_q[BIT_ASYNC_SERIAL_ZERO]}))
      else $error("serial gate map wrong");

   // High phase of a gated clock carries the enable of the cycle before
   a_clock_follows: assert property (
      @(negedge mclk) disable iff (sys_rst)
      unit_clk == $past(unit_enable))
      else $error("gated clock disagrees with enable");

endmodule : deep_sleep_peripheral_clock_gate
`default_nettype wire

// ===== rtl/clk_gate_pkg.sv
package clk_gate_pkg;

   // Register offsets, byte addresses from the system control base
   localparam logic [31:0] SYSCTL_BASE = 32'h400f_e000;
   localparam logic [11:0] OFS_RUN_CFG = 12'h060;
   localparam logic [11:0] OFS_RUN_GATE = 12'h104;
   localparam logic [11:0] OFS_SLEEP_GATE = 12'h114;
   localparam logic [11:0] OFS_DEEP_GATE = 12'h124;
   localparam logic [11:0] OFS_POWER_MODE = 12'h200;

   // Gate bit positions
   localparam int BIT_COMPARATOR_ZERO = 24;
   localparam int BIT_GP_TIMER_TWO = 18;
   localparam int BIT_GP_TIMER_ONE = 17;
   localparam int BIT_GP_TIMER_ZERO = 16;
   localparam int BIT_TWO_WIRE_ZERO = 12;
   localparam int BIT_SYNC_SERIAL_ZERO = 4;
   localparam int BIT_ASYNC_SERIAL_ONE = 1;
   localparam int BIT_ASYNC_SERIAL_ZERO = 0;
   localparam int BIT_AUTO_GATING = 27;
   localparam int NUM_UNITS = 8;

   // Writable bits of a gate register; all others read as zero
   localparam logic [31:0] GATE_MASK = 32'h0107_1013;
   localparam logic [31:0] RUN_CFG_MASK = 32'h0800_0000;
   localparam logic [31:0] GATE_RESET = 32'h0000_0000;
   localparam logic [31:0] RUN_CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] READ_IDLE = 32'h0000_0000;

   // Power mode, Gray coded along run, sleep, deep-sleep
   typedef enum logic [1:0] {
      MODE_RUN = 2'b00,
      MODE_SLEEP = 2'b01,
      MODE_DEEP = 2'b11
   } power_mode_t;

   // Register port request and answer
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic [31:0] rdata;
      logic unmapped;
   } reg_rsp_t;

   // Per-unit peripheral access check
   typedef struct packed {
      logic [NUM_UNITS-1:0] sel;
      logic access;
   } periph_req_t;

endpackage : clk_gate_pkg

// ===== rtl/unit_clock_gate.sv
`timescale 1ns/1ns
`default_nettype none
// Glitch-free gate: enable latched while clock is low, AND with clock
module unit_clock_gate (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic enable,
   output logic gated_clk,
   output logic enable_q
);
   logic en_latch;

   // Registered enable seen by the access checker and the latch
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         enable_q <= 1'b0;
      end else begin
         enable_q <= enable;
      end
   end

   // Latch is transparent only while mclk is low, so no runt pulses
   always_latch begin
      if (!mclk) begin
         en_latch <= enable_q;
      end
   end

   assign gated_clk = mclk & en_latch;

endmodule : unit_clock_gate
`default_nettype wire

// ===== tb/test_deep_sleep_peripheral_clock_gate.sv
`timescale 1ns/1ns
`default_nettype none
module test_deep_sleep_peripheral_clock_gate;
   import clk_gate_pkg::*;
   logic mclk, sys_rst, sleep_req, deep_req, bus_fault, unm;
   reg_req_t req;
   reg_rsp_t rsp;
   periph_req_t periph;
   logic [NUM_UNITS-1:0] unit_clk, unit_enable, sel;
   int num_errors = 0;
   int cmp_count = 0;
   integer seed = 24118;
   logic [31:0] rd_val, w, run_v, slp_v, deep_v;
   int pos [8] = '{0, 1, 4, 12, 16, 17, 18, 24};

   deep_sleep_peripheral_clock_gate u_deep_sleep_peripheral_clock_gate (
      .mclk(mclk), .sys_rst(sys_rst), .req(req), .rsp(rsp),
      .sleep_req(sleep_req), .deep_req(deep_req), .periph(periph),
      .bus_fault(bus_fault), .unit_clk(unit_clk), .unit_enable(unit_enable)
   );

   //////////////////////////////////////////////////////////////////
   // Clock and a hang guard far above the length of the test
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      #40000;
      num_errors++;
      tally_and_finish();
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("errors %0d, comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish

   // Unit order on the enable outputs, comparator in the top bit
   function automatic logic [31:0] to_units(input logic [31:0] v);
      return {24'h00_0000, v[24], v[18], v[17], v[16], v[12], v[4], v[1], v[0]};
   endfunction : to_units

   // One-cycle strobes; the answer is looked at only in the cycle after
   task automatic reg_write(input logic [11:0] a, input logic [31:0] d,
                            input logic exp_unm);
      @(posedge mclk);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge mclk);
      req.wr <= 1'b0;
      #1 check(32'(rsp.unmapped), 32'(exp_unm));
   endtask : reg_write

   task automatic reg_read(input logic [11:0] a, output logic [31:0] d,
                           output logic u);
      @(posedge mclk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge mclk);
      req.rd <= 1'b0;
      #1 d = rsp.rdata;
      u = rsp.unmapped;
   endtask : reg_read

   // Mode pins pass a synchroniser, so poll the status with a bound
   task automatic wait_mode(input logic [31:0] m);
      int n;
      n = 0;
      rd_val = 32'hffff_ffff;
      while (rd_val !== m && n < 20) begin
         reg_read(OFS_POWER_MODE, rd_val, unm);
         n++;
      end
      if (rd_val !== m) begin
         num_errors++;
         tally_and_finish();
      end
      repeat (2) @(posedge mclk);
      #1;
   endtask : wait_mode

   task automatic poke_unit(input logic [NUM_UNITS-1:0] s,
                            input logic [31:0] en);
      @(posedge mclk);
      periph.sel <= s;
      periph.access <= 1'b1;
      @(posedge mclk);
      periph.access <= 1'b0;
      #1 check(32'(bus_fault), 32'(|(s & ~en[NUM_UNITS-1:0])));
   endtask : poke_unit

   //////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      req = '0;
      periph = '0;
      sleep_req = 1'b0;
      deep_req = 1'b0;
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      #1 check(32'(unit_enable), 32'h0000_0000);
      foreach (pos[i]) begin
         if (i < 4) begin
            reg_read(i == 0 ? OFS_RUN_CFG : i == 1 ? OFS_RUN_GATE :
                     i == 2 ? OFS_SLEEP_GATE : OFS_DEEP_GATE, rd_val, unm);
            check(rd_val, i == 0 ? RUN_CFG_RESET : GATE_RESET);
         end
      end
      // Random fills plus all-ones and reserved-only corners
      for (int i = 0; i < 18; i++) begin
         w = i == 0 ? 32'hffff_ffff : i == 1 ? 32'hfef8_efec : $random(seed);
         reg_write(OFS_DEEP_GATE, w, 1'b0);
         reg_read(OFS_DEEP_GATE, rd_val, unm);
         check(rd_val, w & 32'h0107_1013);
      end
      // Walk one bit per unit through the run register and the clock
      foreach (pos[i]) begin
         reg_write(OFS_RUN_GATE, 32'h1 << pos[i], 1'b0);
         repeat (2) @(posedge mclk);
         #1 check(32'(unit_enable), 32'h1 << i);
         check(32'(unit_clk), 32'h1 << i);
         #2 check(32'(unit_clk), 32'h0000_0000);
      end
      // Unmapped places, and the read-only mode status
      reg_read(12'h300, rd_val, unm);
      check(32'(unm), 32'h0000_0001);
      reg_write(OFS_POWER_MODE, 32'h0000_0003, 1'b1);
      reg_write(12'h120, 32'hffff_ffff, 1'b1);
      // Distinct values in each gate register, then step through modes
      run_v = $random(seed);
      slp_v = $random(seed);
      deep_v = ~run_v;
      reg_write(OFS_RUN_GATE, run_v, 1'b0);
      reg_write(OFS_SLEEP_GATE, slp_v, 1'b0);
      reg_write(OFS_DEEP_GATE, deep_v, 1'b0);
      @(posedge mclk);
      deep_req <= 1'b1;
      wait_mode(32'h0000_0003);
      check(32'(unit_enable), to_units(run_v));
      reg_write(OFS_RUN_CFG, 32'hffff_ffff, 1'b0);
      reg_read(OFS_RUN_CFG, rd_val, unm);
      check(rd_val, 32'h0800_0000);
      repeat (2) @(posedge mclk);
      #1 check(32'(unit_enable), to_units(deep_v));
      for (int i = 0; i < 12; i++) begin
         sel = i == 0 ? 8'hff : 8'($random(seed));
         poke_unit(sel, to_units(deep_v));
      end
      @(posedge mclk);
      deep_req <= 1'b0;
      sleep_req <= 1'b1;
      wait_mode(32'h0000_0001);
      check(32'(unit_enable), to_units(slp_v));
      @(posedge mclk);
      sleep_req <= 1'b0;
      wait_mode(32'h0000_0000);
      check(32'(unit_enable), to_units(run_v));
      poke_unit(8'h00, to_units(run_v));
      // Reset in mid-run clears the registers again
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      #1 check(32'(unit_enable), 32'h0000_0000);
      reg_read(OFS_DEEP_GATE, rd_val, unm);
      check(rd_val, GATE_RESET);
      tally_and_finish();
   end
endmodule : test_deep_sleep_peripheral_clock_gate
`default_nettype wire
